// [rtl/imx_pkg.sv]
// Package for the mode, port input and increment execute block.
// Assumes a CPU core supplies decoded opcode bytes and register values.
package imx_pkg;
  localparam logic [7:0] ED_PREFIX = 8'hed;
  localparam logic [7:0] OP_BLK_BYTE_DN = 8'haa;
  localparam logic [7:0] OP_BLK_WORD_DN = 8'h8a;
  localparam logic [7:0] OP_BLK_BYTE_RPT_DN = 8'hba;
  localparam logic [7:0] OP_BLK_WORD_RPT_DN = 8'h9a;
  localparam logic [2:0] MODE_ENC_0 = 3'h0;
  localparam logic [2:0] MODE_ENC_1 = 3'h2;
  localparam logic [2:0] MODE_ENC_2 = 3'h3;
  localparam logic [2:0] MODE_ENC_3 = 3'h1;
  localparam logic [2:0] PAIR_BC = 3'h0;
  localparam logic [2:0] PAIR_DE = 3'h2;
  localparam logic [2:0] PAIR_HL = 3'h4;
  localparam logic [2:0] PAIR_SP = 3'h6;
  localparam logic [2:0] BX_HL_IX = 3'h1;
  localparam logic [2:0] BX_HL_IY = 3'h2;
  localparam logic [2:0] BX_IX_IY = 3'h3;
  localparam logic [7:0] OVF_OPERAND = 8'h7f;
  localparam logic [1:0] IRQ_MODE_RESET = 2'h0;
  // Flag bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_N = 1;
  localparam int FLAG_PV = 2;
  localparam int FLAG_H = 4;
  localparam int FLAG_Z = 6;
  localparam int FLAG_S = 7;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_PORT = 4'h2,
    ST_STORE = 4'h4,
    ST_PAUSE = 4'h8
  } imx_state_type;

  typedef struct packed {
    logic [7:0] b;
    logic [7:0] c;
    logic [15:0] hl;
    logic [7:0] f;
  } imx_regs_type;

  typedef struct packed {
    logic [23:0] addr;
    logic req;
  } imx_io_type;
endpackage

// [rtl/imx_exec.sv]
// Execute logic for mode select, port input, increments and block input down.
// Assumes the core holds operands stable while START is high and honours BUSY.
// Functional notes
// RULE1: Mode select maps encoded field to mode 0-3
// RULE2: Current interrupt mode is readable as status
// RULE3: Port address is page, B, C
// RULE4: Port byte flags: S Z parity, clear H N
// RULE5: User port input traps when user I/O blocked
// RULE6: Byte increment overflow only when operand was 7F
// RULE7: Byte increment sets H, S, Z; clears N
// RULE8: Word increment adds one, flags untouched
// RULE9: Pair field decodes BC DE HL SP
// RULE10: Base index field decodes three sum pairs
// RULE11: Block step stores, drops HL, then B
// RULE12: Single block step: Z from B, set N
// RULE13: Repeat until B zero; zero start gives 256
// RULE14: Repeat pauses for interrupts, PC kept at start
// RULE15: Second byte after prefix selects block variant
// RULE16: Mode select in user mode traps instead
`timescale 1ns/1ps
module imx_exec
  import imx_pkg::*;
(
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic START,
  input wire logic [7:0] OP_PREFIX,
  input wire logic [7:0] OP_BYTE,
  input wire logic USER_MODE,
  input wire logic USER_IO_BLOCK,
  input wire logic IRQ_PENDING,
  input wire logic [15:0] INSN_PC,
  input wire imx_regs_type REGS_IN,
  input wire logic [15:0] IX_IN,
  input wire logic [15:0] IY_IN,
  input wire logic [15:0] SP_IN,
  input wire logic [15:0] DE_IN,
  input wire logic [2:0] BASE_INDEX_FIELD,
  input wire logic [7:0] BYTE_OPERAND,
  input wire logic [15:0] WORD_OPERAND,
  input wire logic IO_ACK,
  input wire logic [15:0] IO_RDATA,
  input wire logic [7:0] IO_PAGE_SRC,
  input wire logic MEM_ACK,
  output imx_io_type IO_REQ,
  output logic MEM_WR,
  output logic MEM_WORD,
  output logic [15:0] MEM_ADDR,
  output logic [15:0] MEM_WDATA,
  output imx_regs_type REGS_OUT,
  output logic [15:0] WORD_RESULT,
  output logic [7:0] BYTE_RESULT,
  output logic [15:0] PAIR_RESULT,
  output logic [15:0] BASE_ADDR,
  output logic [1:0] IRQ_MODE,
  output logic PRIV_TRAP,
  output logic [15:0] RESUME_PC,
  output logic BUSY,
  output logic DONE
);

  function automatic logic even_parity(input logic [7:0] d);
    even_parity = ~^d;
  endfunction

  function automatic logic is_block(input logic [7:0] p, input logic [7:0] o);
    is_block = (p == ED_PREFIX) && ((o == OP_BLK_BYTE_DN) || (o == OP_BLK_WORD_DN)
      || (o == OP_BLK_BYTE_RPT_DN) || (o == OP_BLK_WORD_RPT_DN));
  endfunction

  // Single port read opcodes: ED 01 rrr 000
  function automatic logic is_port_rd(input logic [7:0] p, input logic [7:0] o);
    is_port_rd = (p == ED_PREFIX) && (o[7:6] == 2'b01) && (o[2:0] == 3'b000);
  endfunction

  function automatic logic is_mode_sel(input logic [7:0] p, input logic [7:0] o);
    is_mode_sel = (p == ED_PREFIX) && (o[7:6] == 2'b01) && (o[2:0] == 3'b110);
  endfunction

  imx_state_type state, next_state;
  imx_regs_type regs, next_regs;
  logic [1:0] irq_mode, next_irq_mode;
  logic trap, next_trap;
  logic done, next_done;
  logic word_mode, next_word_mode;
  logic repeat_mode, next_repeat_mode;
  logic single_rd, next_single_rd;
  logic [15:0] data, next_data;
  logic [15:0] resume_pc, next_resume_pc;
  logic [7:0] byte_res, next_byte_res;
  logic [15:0] word_res, next_word_res;
  logic [15:0] pair_res, next_pair_res;
  logic [15:0] base_addr, next_base_addr;
  logic [8:0] inc_sum;
  logic [4:0] half_sum;

  always_comb
  begin
    next_state = state;
    next_regs = regs;
    next_irq_mode = irq_mode;
    next_trap = 1'b0;
    next_done = 1'b0;
    next_word_mode = word_mode;
    next_repeat_mode = repeat_mode;
    next_single_rd = single_rd;
    next_data = data;
    next_resume_pc = resume_pc;
    next_byte_res = byte_res;
    next_word_res = word_res;
    next_pair_res = pair_res;
    next_base_addr = base_addr;
    inc_sum = {1'b0, BYTE_OPERAND} + 9'h001;
    half_sum = {1'b0, BYTE_OPERAND[3:0]} + 5'h01;
    case (state)
      ST_IDLE:
      begin
        if (START)
        begin
          next_regs = REGS_IN;
          next_resume_pc = INSN_PC;
          if ((is_block(OP_PREFIX, OP_BYTE) || is_port_rd(OP_PREFIX, OP_BYTE))
              && USER_MODE && USER_IO_BLOCK) // RULE5
          begin
            next_trap = 1'b1;
            next_done = 1'b1;
          end
          else if (is_mode_sel(OP_PREFIX, OP_BYTE))
          begin
            if (USER_MODE) // RULE16
            begin
              next_trap = 1'b1;
            end
            else
            begin
              case (OP_BYTE[5:3]) // RULE1
                MODE_ENC_0: next_irq_mode = 2'h0;
                MODE_ENC_1: next_irq_mode = 2'h1;
                MODE_ENC_2: next_irq_mode = 2'h2;
                MODE_ENC_3: next_irq_mode = 2'h3;
                default: next_irq_mode = irq_mode;
              endcase
            end
            next_done = 1'b1;
          end
          else if (is_block(OP_PREFIX, OP_BYTE)) // RULE15
          begin
            next_word_mode = ~OP_BYTE[5]; // RULE15
            next_repeat_mode = OP_BYTE[4]; // RULE15
            next_single_rd = 1'b0;
            next_state = ST_PORT;
          end
          else if (is_port_rd(OP_PREFIX, OP_BYTE))
          begin
            next_word_mode = 1'b0;
            next_single_rd = 1'b1;
            next_state = ST_PORT;
          end
          else if (OP_PREFIX == 8'h00 && OP_BYTE[2:0] == 3'b100)
          begin
            // Byte increment
            next_byte_res = inc_sum[7:0];
            next_regs.f[FLAG_S] = inc_sum[7]; // RULE7
            next_regs.f[FLAG_Z] = (inc_sum[7:0] == 8'h00); // RULE7
            next_regs.f[FLAG_H] = half_sum[4]; // RULE7
            next_regs.f[FLAG_N] = 1'b0; // RULE7
            next_regs.f[FLAG_PV] = (BYTE_OPERAND == OVF_OPERAND); // RULE6
            next_done = 1'b1;
          end
          else if (OP_PREFIX == 8'h00 && OP_BYTE[7:6] == 2'b00 && OP_BYTE[2:0] == 3'b011)
          begin
            // Word increment keeps every flag
            next_word_res = WORD_OPERAND + 16'h0001; // RULE8
            case (OP_BYTE[5:3]) // RULE9
              PAIR_BC: next_pair_res = {REGS_IN.b, REGS_IN.c} + 16'h0001;
              PAIR_DE: next_pair_res = DE_IN + 16'h0001;
              PAIR_HL: next_pair_res = REGS_IN.hl + 16'h0001;
              PAIR_SP: next_pair_res = SP_IN + 16'h0001;
              default: next_pair_res = WORD_OPERAND + 16'h0001;
            endcase
            next_done = 1'b1;
          end
          else
          begin
            next_done = 1'b1;
          end
          case (BASE_INDEX_FIELD) // RULE10
            BX_HL_IX: next_base_addr = REGS_IN.hl + IX_IN;
            BX_HL_IY: next_base_addr = REGS_IN.hl + IY_IN;
            BX_IX_IY: next_base_addr = IX_IN + IY_IN;
            default: next_base_addr = base_addr;
          endcase
        end
      end
      ST_PORT:
      begin
        if (IO_ACK)
        begin
          next_data = IO_RDATA;
          if (single_rd)
          begin
            next_byte_res = IO_RDATA[7:0];
            next_regs.f[FLAG_S] = IO_RDATA[7]; // RULE4
            next_regs.f[FLAG_Z] = (IO_RDATA[7:0] == 8'h00); // RULE4
            next_regs.f[FLAG_PV] = even_parity(IO_RDATA[7:0]); // RULE4
            next_regs.f[FLAG_H] = 1'b0; // RULE4
            next_regs.f[FLAG_N] = 1'b0; // RULE4
            next_done = 1'b1;
            next_state = ST_IDLE;
          end
          else
          begin
            next_state = ST_STORE;
          end
        end
      end
      ST_STORE:
      begin
        if (MEM_ACK)
        begin
          // Wraps from 00 to FF, so a zero start yields 256 steps
          next_regs.hl = regs.hl - (word_mode ? 16'h0002 : 16'h0001); // RULE11
          next_regs.b = regs.b - 8'h01; // RULE11
          next_regs.f[FLAG_N] = 1'b1; // RULE12
          next_regs.f[FLAG_Z] = (regs.b == 8'h01); // RULE12
          if (!repeat_mode || regs.b == 8'h01) // RULE13
          begin
            next_done = 1'b1;
            next_state = ST_IDLE;
          end
          else if (IRQ_PENDING) // RULE14
          begin
            next_state = ST_PAUSE;
          end
          else
          begin
            next_state = ST_PORT;
          end
        end
      end
      ST_PAUSE:
      begin
        // Hands the partial state back; core reissues from the saved PC
        next_done = 1'b1; // RULE14
        next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (!RESETN)
    begin
      state <= ST_IDLE;
      regs <= '0;
      irq_mode <= IRQ_MODE_RESET;
      trap <= 1'b0;
      done <= 1'b0;
      word_mode <= 1'b0;
      repeat_mode <= 1'b0;
      single_rd <= 1'b0;
      data <= 16'h0000;
      resume_pc <= 16'h0000;
      byte_res <= 8'h00;
      word_res <= 16'h0000;
      pair_res <= 16'h0000;
      base_addr <= 16'h0000;
    end
    else
    begin
      state <= next_state;
      regs <= next_regs;
      irq_mode <= next_irq_mode;
      trap <= next_trap;
      done <= next_done;
      word_mode <= next_word_mode;
      repeat_mode <= next_repeat_mode;
      single_rd <= next_single_rd;
      data <= next_data;
      resume_pc <= next_resume_pc;
      byte_res <= next_byte_res;
      word_res <= next_word_res;
      pair_res <= next_pair_res;
      base_addr <= next_base_addr;
    end
  end

  // Page is read live from the core, so it must hold steady while BUSY
  logic [7:0] io_page;
  assign io_page = IO_PAGE_SRC;
  assign IO_REQ.addr = {io_page, regs.b, regs.c}; // RULE3
  assign IO_REQ.req = (state == ST_PORT);
  assign MEM_WR = (state == ST_STORE); // RULE11
  assign MEM_WORD = word_mode;
  assign MEM_ADDR = regs.hl; // RULE11
  assign MEM_WDATA = data;
  assign REGS_OUT = regs;
  assign WORD_RESULT = word_res;
  assign BYTE_RESULT = byte_res;
  assign PAIR_RESULT = pair_res;
  assign BASE_ADDR = base_addr;
  assign IRQ_MODE = irq_mode; // RULE2
  assign PRIV_TRAP = trap;
  assign RESUME_PC = resume_pc; // RULE14
  assign BUSY = (state != ST_IDLE);
  assign DONE = done;
endmodule

// [dv/imx_exec_assertions.sv]
// Checker for the execute block, bound to its top ports.
// Assumes operands stay stable while an instruction runs.
`timescale 1ns/1ps
module imx_exec_checker
  import imx_pkg::*;
(
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic START,
  input wire logic [7:0] OP_PREFIX,
  input wire logic [7:0] OP_BYTE,
  input wire logic USER_MODE,
  input wire logic USER_IO_BLOCK,
  input wire imx_regs_type REGS_IN,
  input wire logic [7:0] BYTE_OPERAND,
  input wire logic MEM_ACK,
  input wire logic [7:0] IO_PAGE_SRC,
  input wire imx_io_type IO_REQ,
  input wire logic MEM_WR,
  input wire logic MEM_WORD,
  input wire logic [15:0] MEM_ADDR,
  input wire imx_regs_type REGS_OUT,
  input wire logic [7:0] BYTE_RESULT,
  input wire logic [1:0] IRQ_MODE,
  input wire logic PRIV_TRAP,
  input wire logic BUSY,
  input wire logic DONE
);
  logic ed;
  logic plain;
  logic inc8;
  logic inc16;
  logic blk;
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RESETN);
  assign ed = START && !BUSY && OP_PREFIX == ED_PREFIX;
  assign plain = START && !BUSY && OP_PREFIX == 8'h00 && OP_BYTE[7:6] == 2'h0;
  assign inc8 = plain && OP_BYTE[2:0] == 3'h4;
  assign inc16 = plain && OP_BYTE[3:0] == 4'h3;
  assign blk = OP_BYTE inside {OP_BLK_BYTE_DN, OP_BLK_WORD_DN, OP_BLK_BYTE_RPT_DN};
  chk_mode_three:
    assert property (ed && !USER_MODE && OP_BYTE == 8'h4e |=> IRQ_MODE == 2'h3)
    else $error("mode field 001 gave wrong mode");
  chk_mode_user_trap:
    assert property (ed && USER_MODE && OP_BYTE[7:6] == 2'h1 && OP_BYTE[2:0] == 3'h6
      |=> PRIV_TRAP && $stable(IRQ_MODE))
    else $error("user mode select not trapped");
  chk_io_user_trap:
    assert property (ed && USER_MODE && USER_IO_BLOCK && blk |=> PRIV_TRAP && !IO_REQ.req)
    else $error("blocked user port input not trapped");
  chk_port_addr:
    assert property ($rose(IO_REQ.req) && $past(START)
      |-> IO_REQ.addr == {IO_PAGE_SRC, REGS_IN.b, REGS_IN.c})
    else $error("port address not page, B then C");
  chk_inc_overflow:
    assert property (inc8 |=> DONE && BYTE_RESULT == $past(BYTE_OPERAND) + 8'h01
      && REGS_OUT.f[FLAG_PV] == ($past(BYTE_OPERAND) == OVF_OPERAND))
    else $error("byte increment sum or overflow wrong");
  chk_inc_flags:
    assert property (inc8 |=> REGS_OUT.f[FLAG_C] == $past(REGS_IN.f[FLAG_C])
      && !REGS_OUT.f[FLAG_N] && REGS_OUT.f[FLAG_Z] == (BYTE_RESULT == 8'h00))
    else $error("byte increment flags wrong");
  chk_word_flags:
    assert property (inc16 |=> REGS_OUT.f == $past(REGS_IN.f))
    else $error("word increment touched flags");
  chk_step_update:
    assert property (MEM_ACK && MEM_WR |=> REGS_OUT.f[FLAG_N]
      && REGS_OUT.hl == $past(MEM_ADDR) - ($past(MEM_WORD) ? 16'h0002 : 16'h0001))
    else $error("block step pointer or flags wrong");
  cov_inc: cover property (inc8);
  cov_word_step: cover property (MEM_ACK && MEM_WORD);
  cov_trap: cover property (PRIV_TRAP);
endmodule

bind imx_exec imx_exec_checker imx_exec_checker_i (
  .CLK(CLK), .RESETN(RESETN), .START(START), .OP_PREFIX(OP_PREFIX), .OP_BYTE(OP_BYTE),
  .USER_MODE(USER_MODE), .USER_IO_BLOCK(USER_IO_BLOCK), .REGS_IN(REGS_IN),
  .BYTE_OPERAND(BYTE_OPERAND), .MEM_ACK(MEM_ACK), .IO_PAGE_SRC(IO_PAGE_SRC),
  .IO_REQ(IO_REQ), .MEM_WR(MEM_WR),
  .MEM_WORD(MEM_WORD), .MEM_ADDR(MEM_ADDR), .REGS_OUT(REGS_OUT),
  .BYTE_RESULT(BYTE_RESULT), .IRQ_MODE(IRQ_MODE), .PRIV_TRAP(PRIV_TRAP),
  .BUSY(BUSY), .DONE(DONE)
);

// [dv/imx_bus_model.sv]
// Bus partner: answers port reads and memory writes.
// Assumes requests hold until acknowledged.
`timescale 1ns/1ps
module imx_bus_model
  import imx_pkg::*;
(
  input wire logic clk,
  input wire imx_io_type io_req,
  input wire logic mem_wr,
  input wire logic mem_word,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic [15:0] port_data,
  input wire logic slow,
  output logic io_ack,
  output logic [15:0] io_rdata,
  output logic mem_ack,
  output logic [15:0] wr_addr,
  output logic [15:0] wr_data,
  output logic wr_word,
  output int writes
);
  int stall = 0;
  initial
  begin
    io_ack = 1'b0;
    mem_ack = 1'b0;
    io_rdata = 16'h0000;
    wr_addr = 16'h0000;
    wr_data = 16'h0000;
    wr_word = 1'b0;
    writes = 0;
  end
  always @(posedge clk)
  begin
    io_ack <= 1'b0;
    mem_ack <= 1'b0;
    // Released bus toggles, so a late sample cannot pass for data
    io_rdata <= ~io_rdata;
    if ((io_req.req || mem_wr) && !io_ack && !mem_ack)
    begin
      stall <= (slow && stall < 3) ? stall + 1 : 0;
      if (!slow || stall == 3)
      begin
        io_ack <= io_req.req;
        mem_ack <= mem_wr;
        if (io_req.req)
          io_rdata <= port_data;
        // Captured as the write is granted, before the pointer moves
        if (mem_wr)
        begin
          wr_addr <= mem_addr;
          wr_data <= mem_wdata;
          wr_word <= mem_word;
        end
        writes <= writes + int'(mem_wr);
      end
    end
  end
endmodule

// [dv/irq_mode_port_input_increment_exec_tb_top.sv]
// Testbench for mode select, port input, increments and block input.
// Assumes the bus model answers port and memory cycles.
`timescale 1ns/1ps
module irq_mode_port_input_increment_exec_tb_top
  import imx_pkg::*;
;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic start = 1'b0;
  logic user = 1'b0;
  logic uio = 1'b0;
  logic irq = 1'b0;
  logic slow = 1'b0;
  logic [7:0] pre = 8'h00;
  logic [7:0] op = 8'h00;
  logic [7:0] bop = 8'h00;
  logic [15:0] pc = 16'h4321;
  logic [15:0] wv = 16'h0000;
  logic [15:0] pdata = 16'h0000;
  logic [7:0] page = 8'h33;
  logic [2:0] bxf = 3'h0;
  logic [15:0] maddr, mwdata, wres, base, waddr, wdata;
  logic wword;
  imx_regs_type rin = '0;
  imx_regs_type rout;
  imx_io_type ioq;
  logic ioack, mack, mwr, mword, busy, done, trap;
  logic [15:0] rdata, pres, rpc;
  logic [7:0] bres;
  logic [1:0] mode;
  int writes;
  int mismatches = 0;
  int checks_done = 0;
  imx_exec imx_exec_i (
    .CLK(clk), .RESETN(resetn), .START(start), .OP_PREFIX(pre), .OP_BYTE(op),
    .USER_MODE(user), .USER_IO_BLOCK(uio), .IRQ_PENDING(irq), .INSN_PC(pc),
    .REGS_IN(rin), .IX_IN(16'h0100), .IY_IN(16'h0020), .SP_IN(~wv), .DE_IN(wv),
    .BASE_INDEX_FIELD(bxf), .BYTE_OPERAND(bop), .WORD_OPERAND(wv),
    .IO_ACK(ioack), .IO_RDATA(rdata), .IO_PAGE_SRC(page), .MEM_ACK(mack), .IO_REQ(ioq),
    .MEM_WR(mwr), .MEM_WORD(mword), .MEM_ADDR(maddr), .MEM_WDATA(mwdata), .REGS_OUT(rout),
    .WORD_RESULT(wres), .BYTE_RESULT(bres), .PAIR_RESULT(pres), .BASE_ADDR(base),
    .IRQ_MODE(mode), .PRIV_TRAP(trap), .RESUME_PC(rpc), .BUSY(busy), .DONE(done)
  );
  imx_bus_model imx_bus_model_i (
    .clk(clk), .io_req(ioq), .mem_wr(mwr), .mem_word(mword), .mem_addr(maddr),
    .mem_wdata(mwdata), .port_data(pdata), .slow(slow), .io_ack(ioack), .io_rdata(rdata),
    .mem_ack(mack), .wr_addr(waddr), .wr_data(wdata), .wr_word(wword), .writes(writes)
  );
  initial
  begin
    forever #50 clk = ~clk;
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Waits on DONE under a bound; a hung design counts as a mismatch
  task automatic run(input logic [7:0] p, input logic [7:0] o);
    int n;
    n = 0;
    // One edge apart so START is never lowered and raised in one step
    @(posedge clk);
    #5 pre = p;
    op = o;
    start = 1'b1;
    @(posedge clk);
    #5 start = 1'b0;
    while (done !== 1'b1 && n < 3000)
    begin
      @(posedge clk);
      #5 n = n + 1;
    end
    check("done", done, 16'h0001);
  endtask
  task automatic t_mode();
    logic [2:0] enc [4];
    enc = '{MODE_ENC_0, MODE_ENC_1, MODE_ENC_2, MODE_ENC_3};
    for (int i = 0; i < 4; i++)
    begin
      run(ED_PREFIX, {2'h1, enc[i], 3'h6});
      check("mode", mode, i[1:0]);
    end
    user = 1'b1;
    run(ED_PREFIX, {2'h1, MODE_ENC_1, 3'h6});
    check("trap", trap, 1'b1);
    check("mode", mode, 2'h3);
    user = 1'b0;
  endtask
  task automatic t_inc();
    rin.f = 8'h01;
    bop = 8'h7f;
    run(8'h00, 8'h3c);
    check("sum", bres, 8'h80);
    check("flags", rout.f, 8'h95);
    bop = 8'hff;
    run(8'h00, 8'h3c);
    check("flags", rout.f, 8'h51);
  endtask
  task automatic t_word();
    logic [15:0] exp [4];
    logic [15:0] bexp [4];
    rin = '{8'h3f, 8'h12, 16'h2454, 8'hd5};
    wv = 16'h1234;
    exp = '{16'h3f13, 16'h1235, 16'h2455, 16'hedcc};
    bexp = '{16'h0000, 16'h2554, 16'h2474, 16'h0120};
    for (int k = 0; k < 4; k++)
    begin
      run(8'h00, {2'h0, k[1:0], 4'h3});
      check("pair", pres, exp[k]);
      check("flags", rout.f, 8'hd5);
      check("word", wres, 16'h1235);
    end
    for (int j = 1; j < 4; j++)
    begin
      bxf = j[2:0];
      run(8'h00, 8'h03);
      check("base", base, bexp[j]);
    end
    bxf = 3'h0;
  endtask
  task automatic t_in();
    rin = '{8'h16, 8'h50, 16'h0023, 8'h01};
    pdata = 16'h0081;
    run(ED_PREFIX, 8'h40);
    check("data", bres, 8'h81);
    check("flags", rout.f, 8'h85);
    check("addr", ioq.addr[23:8], 16'h3316);
    check("port", 16'(ioq.addr[7:0]), 16'h0050);
  endtask
  task automatic t_step();
    int w;
    w = writes;
    rin = '{8'h15, 8'h64, 16'h5002, 8'h00};
    pdata = 16'h8d07;
    run(ED_PREFIX, OP_BLK_BYTE_DN);
    check("hl", rout.hl, 16'h5001);
    check("b", rout.b, 8'h14);
    check("flags", rout.f, 8'h02);
    check("waddr", waddr, 16'h5002);
    check("wdata", wdata, 16'h8d07);
    check("wword", wword, 16'h0000);
    rin = '{8'h01, 8'h64, 16'h5002, 8'h00};
    slow = 1'b1;
    run(ED_PREFIX, OP_BLK_WORD_DN);
    check("hl", rout.hl, 16'h5000);
    check("flags", rout.f, 8'h42);
    check("writes", 16'(writes - w), 16'h0002);
    check("waddr", waddr, 16'h5002);
    check("wword", wword, 16'h0001);
    slow = 1'b0;
  endtask
  task automatic t_rpt();
    int w;
    w = writes;
    rin = '{8'h00, 8'h46, 16'h1000, 8'h81};
    run(ED_PREFIX, OP_BLK_BYTE_RPT_DN);
    check("writes", 16'(writes - w), 16'h0100);
    check("hl", rout.hl, 16'h0f00);
    check("flags", rout.f, 8'hc3);
    check("waddr", waddr, 16'h0f01);
    rin = '{8'h03, 8'h46, 16'h5218, 8'h00};
    irq = 1'b1;
    w = writes;
    run(ED_PREFIX, OP_BLK_BYTE_RPT_DN);
    check("b", rout.b, 8'h02);
    check("pc", rpc, pc);
    check("writes", 16'(writes - w), 16'h0001);
    irq = 1'b0;
    rin = '{8'h02, 8'h55, 16'h4002, 8'h00};
    w = writes;
    run(ED_PREFIX, OP_BLK_WORD_RPT_DN);
    check("writes", 16'(writes - w), 16'h0002);
    check("hl", rout.hl, 16'h3ffe);
    check("flags", rout.f, 8'h42);
  endtask
  task automatic t_trap();
    int w;
    user = 1'b1;
    rin = '{8'h05, 8'h64, 16'h3000, 8'h00};
    for (int u = 0; u < 2; u++)
    begin
      uio = u[0];
      w = writes;
      run(ED_PREFIX, OP_BLK_BYTE_DN);
      check("trap", trap, u[0]);
      check("writes", 16'(writes - w), 16'(1 - u));
    end
    user = 1'b0;
    uio = 1'b0;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    complete_run();
  end
  initial
  begin
    repeat (3) @(posedge clk);
    #5 resetn = 1'b1;
    check("mode", mode, IRQ_MODE_RESET);
    t_mode();
    t_inc();
    t_word();
    t_in();
    t_step();
    t_rpt();
    t_trap();
    complete_run();
  end
endmodule
